// *** shared/dps_regs.vh ***
// constants of the burst sram port: widths, depths, latencies and timing counts
`ifndef DPS_REGS_VH
`define DPS_REGS_VH

// address width of the modelled array (words of two beats)
`define DPS_ADDR_W 8
// width of one beat on the data pins
`define DPS_WORD_W 18
// width of one byte lane
`define DPS_LANE_W 9
// depth of the write commit queue and its pointer width
`define DPS_FIFO_DEPTH 8
`define DPS_FIFO_AW 3
// width of one queued write: address, four lane enables, two beats
`define DPS_FIFO_W 48
// read latency in strobe cycles, loop on and legacy mode
`define DPS_LAT_DLL 2
`define DPS_LAT_LEGACY 1
// strobe cycles between impedance updates
`define DPS_ZQ_CYCLES 11'h400
// strobe cycles of stable clock before the loop reports lock
`define DPS_DLL_LOCK_CYC 14'h2800
// least clock stop that resets the loop, in ns
`define DPS_DLL_RESET_NS 30
// period of core_clk in ns
`define DPS_CLK_NS 20
// least stop in core cycles, rounded up
`define DPS_DLL_RESET_CYC ((`DPS_DLL_RESET_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
// core cycles between strobe edges in normal running
`define DPS_HALF_PERIOD_CYC 4
// synchroniser reset pattern: strobes high, selects and lane enables idle, loop on
`define DPS_SYNC_IDLE 37'h1F80000010

`endif

// *** sim/dps_ctrl_model.sv ***
// controller model: the complementary input strobes
`timescale 1ns/1ps
`default_nettype none
module dps_ctrl_model (
    input wire logic strobeStall,
    output logic posInStrobe,
    output logic negInStrobe
);
    // strobes of 160 ns period, phase unrelated to core_clk
    initial
    begin
        posInStrobe = 0;
        negInStrobe = 1;
        #7;
        forever
        begin
            #80;
            // steady period; a stall request freezes both strobes, which resets the loop
            if (!strobeStall)
            begin
                posInStrobe = ~posInStrobe;
                negInStrobe = ~negInStrobe;
            end
        end
    end
endmodule // dps_ctrl_model
`default_nettype wire

// *** sim/dps_sram_port_asserts.sv ***
// checker for the burst sram port
`timescale 1ns/1ps
`default_nettype none
module dps_sram_port_asserts (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic posInStrobe,
    input wire logic negInStrobe,
    input wire logic readPortSelectN,
    input wire logic dllOffN,
    input wire logic [3:0] impedanceRefPin,
    input wire logic readDataOe,
    input wire logic readValidFlag,
    input wire logic echoStrobePos,
    input wire logic echoStrobeNeg,
    input wire logic dllLocked,
    input wire logic [3:0] driveStrength,
    input wire logic impedanceUpdate
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // a burst starts driving the pins
    sequence oeOpen;
        $rose(readDataOe);
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !readDataOe)
        else $error("read pins driven in reset");
    a_lat_two: assert property (oeOpen ##0 dllOffN |-> !$past(readPortSelectN, 18))
        else $error("burst without read two cycles before");
    a_lat_one: assert property (oeOpen ##0 !dllOffN |-> !$past(readPortSelectN, 10))
        else $error("burst without read one cycle before");
    a_flag_lead: assert property (oeOpen |-> $past(readValidFlag))
        else $error("valid flag did not lead data");
    a_oe_close: assert property ($fell(readDataOe) |-> !readValidFlag)
        else $error("pins released with burst due");
    a_echo_pos: assert property ($rose(posInStrobe) |-> ##[1:4] $rose(echoStrobePos))
        else $error("positive echo missing");
    a_echo_neg: assert property ($rose(negInStrobe) |-> ##[1:4] $rose(echoStrobeNeg))
        else $error("negative echo missing");
    a_zq_gap: assert property (impedanceUpdate |=> !impedanceUpdate [*8])
        else $error("impedance updates too close");
    a_zq_load: assert property (impedanceUpdate && $stable(impedanceRefPin)
        |-> ##[0:1] driveStrength == impedanceRefPin)
        else $error("drive strength not loaded");
    a_lock_off: assert property (!dllOffN [*3] |=> !dllLocked)
        else $error("lock shown with loop off");
endmodule // dps_sram_port_asserts
bind dps_sram_port dps_sram_port_asserts u_chk (.core_clk(core_clk), .rst_b(rst_b),
    .posInStrobe(posInStrobe), .negInStrobe(negInStrobe), .readPortSelectN(readPortSelectN),
    .dllOffN(dllOffN), .impedanceRefPin(impedanceRefPin), .readDataOe(readDataOe),
    .readValidFlag(readValidFlag), .echoStrobePos(echoStrobePos), .echoStrobeNeg(echoStrobeNeg),
    .dllLocked(dllLocked), .driveStrength(driveStrength), .impedanceUpdate(impedanceUpdate));
`default_nettype wire

// *** sim/tb_dps_sram_port.sv ***
// testbench for the burst sram port
`timescale 1ns/1ps
`default_nettype none
module tb_dps_sram_port;
    logic core_clk, rst_b = 0, posInStrobe, negInStrobe;
    logic readPortSelectN = 1, writePortSelectN = 1, dllOffN = 1, arrayHold = 0;
    logic strobeStall = 0;
    logic [1:0] byteWriteSelectN = 2'h3;
    logic [7:0] address = 8'h00;
    logic [17:0] writeData = 18'h00000, readData;
    logic [3:0] impedanceRefPin = 4'hA, driveStrength;
    logic readDataOe, readValidFlag, echoStrobePos, echoStrobeNeg, dllLocked;
    logic impedanceUpdate, writeReady, writeDropped;
    int bad_count = 0, tests_run = 0;
    // core clock
    initial
    begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end
    dps_ctrl_model u_ctrl (.strobeStall(strobeStall), .posInStrobe(posInStrobe),
        .negInStrobe(negInStrobe));
    // short lock count keeps the run brief
    dps_sram_port #(.LOCK_CYCLES(14'h0010)) u_dps_sram_port (.core_clk(core_clk), .rst_b(rst_b),
        .posInStrobe(posInStrobe), .negInStrobe(negInStrobe), .readPortSelectN(readPortSelectN),
        .writePortSelectN(writePortSelectN), .byteWriteSelectN(byteWriteSelectN),
        .address(address), .writeData(writeData), .dllOffN(dllOffN),
        .impedanceRefPin(impedanceRefPin), .arrayHold(arrayHold), .readData(readData),
        .readDataOe(readDataOe), .readValidFlag(readValidFlag), .echoStrobePos(echoStrobePos),
        .echoStrobeNeg(echoStrobeNeg), .dllLocked(dllLocked), .driveStrength(driveStrength),
        .impedanceUpdate(impedanceUpdate), .writeReady(writeReady), .writeDropped(writeDropped));
    // compare and count
    task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // wait a strobe pin rise, then until its sampling is over
    task automatic stp(input bit p);
        if (p)
            @(posedge posInStrobe);
        else
            @(posedge negInStrobe);
        repeat (4) @(posedge core_clk);
    endtask
    // write burst: beat0 with select, then address and beat1
    task automatic wr(input logic [7:0] a, input logic [17:0] d0, d1, input logic [1:0] e0, e1);
        stp(0);
        writePortSelectN <= 0;
        writeData <= d0;
        byteWriteSelectN <= e0;
        stp(1);
        writePortSelectN <= 1;
        address <= a;
        writeData <= d1;
        byteWriteSelectN <= e1;
    endtask
    // read burst and judge both beats
    task automatic rd(input logic [7:0] a, input int lat, input logic [17:0] q0, q1);
        stp(0);
        readPortSelectN <= 0;
        address <= a;
        stp(1);
        readPortSelectN <= 1;
        repeat (lat) @(posedge posInStrobe);
        repeat (4) @(posedge core_clk);
        #1;
        chk("beat0", q0, readData);
        chk("oe", 18'h1, {17'h0, readDataOe});
        @(posedge negInStrobe);
        repeat (4) @(posedge core_clk);
        #1;
        chk("beat1", q1, readData);
        chk("oe beat1", 18'h1, {17'h0, readDataOe});
    endtask
    // full burst, read on the very next strobe cycle, pins released after
    task automatic t_burst;
        chk("lock", 18'h1, {17'h0, dllLocked});
        wr(8'h21, 18'h1A5A5, 18'h25A5A, 2'h0, 2'h0);
        rd(8'h21, 2, 18'h1A5A5, 18'h25A5A);
        @(posedge posInStrobe);
        repeat (6) @(posedge core_clk);
        #1;
        chk("oe off", 18'h0, {17'h0, readDataOe});
    endtask
    // lane 0 only on beat0, lane 1 only on beat1
    task automatic t_lanes;
        wr(8'h21, 18'h3FFFF, 18'h3FFFF, 2'h2, 2'h1);
        rd(8'h21, 2, (18'h1A5A5 & 18'h3FE00) | 18'h001FF, (18'h25A5A & 18'h001FF) | 18'h3FE00);
    endtask
    // loop off: one cycle latency, no lock
    task automatic t_legacy;
        @(posedge core_clk);
        dllOffN <= 0;
        repeat (40) @(posedge core_clk);
        #1;
        chk("lock", 18'h0, {17'h0, dllLocked});
        rd(8'h21, 1, 18'h1A5FF, 18'h3FE5A);
        @(posedge core_clk);
        dllOffN <= 1;
    endtask
    // held array fills the queue, the ninth burst is dropped, then the queue drains
    task automatic t_full;
        int i;
        @(posedge core_clk);
        arrayHold <= 1'b1;
        for (i = 0; i < 9; i++)
            wr(8'h40 + 8'(i), 18'h0AAAA, 18'h15555, 2'h0, 2'h0);
        #1;
        chk("ready full", 18'h0, {17'h0, writeReady});
        @(posedge negInStrobe);
        repeat (3) @(posedge core_clk);
        #1;
        chk("dropped", 18'h1, {17'h0, writeDropped});
        @(posedge core_clk);
        arrayHold <= 1'b0;
        repeat (12) @(posedge core_clk);
        #1;
        chk("ready drained", 18'h1, {17'h0, writeReady});
        rd(8'h47, 2, 18'h0AAAA, 18'h15555);
    endtask
    // stopped strobes drop the lock, running strobes bring it back
    task automatic t_relock;
        @(posedge core_clk);
        strobeStall <= 1'b1;
        repeat (20) @(posedge core_clk);
        #1;
        chk("lock lost", 18'h0, {17'h0, dllLocked});
        @(posedge core_clk);
        strobeStall <= 1'b0;
        repeat (200) @(posedge core_clk);
        #1;
        chk("relock", 18'h1, {17'h0, dllLocked});
    endtask
    // periodic impedance update takes the new reference
    task automatic t_zq;
        int i;
        @(posedge core_clk);
        impedanceRefPin <= 4'h5;
        repeat (4) @(posedge core_clk);
        #1;
        for (i = 0; i < 9000 && impedanceUpdate !== 1'b1; i++)
        begin
            @(posedge core_clk);
            #1;
        end
        chk("zq pulse", 18'h1, {17'h0, impedanceUpdate});
        chk("drive", 18'h5, {14'h0, driveStrength});
    endtask
    // verdict and end of run
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog on a hang
    initial
    begin
        #400000;
        bad_count++;
        test_done();
    end
    // main sequence
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1;
        #1;
        chk("oe reset", 18'h0, {17'h0, readDataOe});
        repeat (200) @(posedge core_clk);
        t_burst();
        t_lanes();
        t_legacy();
        t_full();
        t_relock();
        t_zq();
        test_done();
    end
endmodule // tb_dps_sram_port
`default_nettype wire

// *** verilog/dps_sram_port.v ***
// burst sram port: strobe sampling, read pipeline, write queue, array, echo, loop and impedance
// Function
// - read starts on read select low at rise
// - loop on: first beat two cycles later
// - loop off: read latency one cycle
// - every access two beats in one cycle
// - low beat on positive, next on negative
// - deselect finishes reads, then outputs float
// - write select low captures first beat
// - negative edge takes address, commits burst
// - deselected write port ignores write inputs
// - lane enables sampled per beat
// - read and write ports run independently
// - read returns data drained to the array, not writes still queued
// - selects sampled on positive edges only
// - inputs registered except arrayHold, outputs from registers except writeReady
// - impedance update every 1024 cycles
// - free running echo strobes follow inputs
// - valid flag half cycle before data
// - loop locks after 10240 stable cycles
// - both ports deselected, outputs float after reset
// - lane 0 bits 8:0, lane 1 bits 17:9
`timescale 1ns/1ps
`default_nettype none
`include "dps_regs.vh"

// write commit queue between the pin side and the array
module dps_write_fifo #(
    parameter WIDTH = 48,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rstB,
    input wire [WIDTH-1:0] inData,
    input wire inValid,
    output wire inReady,
    output wire [WIDTH-1:0] outData,
    output wire outValid,
    input wire outReady
);
    // storage words
    reg [WIDTH-1:0] store [0:DEPTH-1];
    // pointers with one wrap bit
    reg [AW:0] wrPtr;
    reg [AW:0] rdPtr;
    // empty when pointers match, full when only the wrap bit differs
    wire empty = (wrPtr == rdPtr);
    wire full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
    wire doPush = inValid && !full;
    wire doPop = outReady && !empty;

    assign inReady = !full;
    assign outValid = !empty;
    assign outData = store[rdPtr[AW-1:0]];

    // storage write, no reset needed on the data
    always @(posedge clk)
    begin
        if (doPush)
        begin
            store[wrPtr[AW-1:0]] <= inData;
        end
    end

    // pointer update
    always @(posedge clk)
    begin
        if (!rstB)
        begin
            wrPtr <= {(AW+1){1'b0}};
            rdPtr <= {(AW+1){1'b0}};
        end
        else
        begin
            if (doPush)
            begin
                wrPtr <= wrPtr + {{AW{1'b0}}, 1'b1};
            end
            if (doPop)
            begin
                rdPtr <= rdPtr + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // dps_write_fifo

// device side of the burst sram interface
module dps_sram_port #(
    parameter [13:0] LOCK_CYCLES = `DPS_DLL_LOCK_CYC
) (
    input wire core_clk,
    input wire rst_b,
    input wire posInStrobe,
    input wire negInStrobe,
    input wire readPortSelectN,
    input wire writePortSelectN,
    input wire [1:0] byteWriteSelectN,
    input wire [7:0] address,
    input wire [17:0] writeData,
    input wire dllOffN,
    input wire [3:0] impedanceRefPin,
    input wire arrayHold,
    output reg [17:0] readData,
    output reg readDataOe,
    output reg readValidFlag,
    output reg echoStrobePos,
    output reg echoStrobeNeg,
    output reg dllLocked,
    output reg [3:0] driveStrength,
    output reg impedanceUpdate,
    output wire writeReady,
    output reg writeDropped
);
    // gap between strobe edges that counts as a stopped clock
    localparam integer GAP_SUM = `DPS_HALF_PERIOD_CYC + `DPS_DLL_RESET_CYC;
    localparam [4:0] GAP_LIMIT = GAP_SUM[4:0];

    // all pins except arrayHold gathered for the two stage synchroniser
    wire [36:0] pinBus = {posInStrobe, negInStrobe, readPortSelectN, writePortSelectN,
        byteWriteSelectN, address, writeData, dllOffN, impedanceRefPin};
    // first and second synchroniser stages
    reg [36:0] syncA;
    reg [36:0] syncB;
    // third flops for edge finding on the strobes
    reg posLast;
    reg negLast;

    // synchronised pin views
    wire sPos = syncB[36];
    wire sNeg = syncB[35];
    wire sRpsN = syncB[34];
    wire sWpsN = syncB[33];
    wire [1:0] sBwsN = syncB[32:31];
    wire [7:0] sAddr = syncB[30:23];
    wire [17:0] sWdata = syncB[22:5];
    wire sDllOn = syncB[4];
    wire [3:0] sZq = syncB[3:0];
    // one cycle pulses on strobe rising edges
    wire posRise = sPos && !posLast;
    wire negRise = sNeg && !negLast;

    // the array: low beat in bits 17:0, high beat in bits 35:18
    reg [35:0] mem [0:255];

    // read pipeline stages: valid and address
    reg rdV0;
    reg rdV1;
    reg [7:0] rdA0;
    reg [7:0] rdA1;
    // second beat waiting for the negative edge
    reg [17:0] beatHigh;
    reg beatHighDue;
    // stage that leaves at the next positive edge
    wire deliverV = sDllOn ? rdV1 : rdV0;
    wire [7:0] deliverA = sDllOn ? rdA1 : rdA0;
    wire [35:0] deliverWord = mem[deliverA];

    // write side: first beat and its lane enables
    reg wrPend;
    reg [17:0] wrLow;
    reg [1:0] wrLowEn;
    // queued write and drain side
    wire pushValid = negRise && wrPend;
    wire [47:0] pushData = {sAddr, ~sBwsN, wrLowEn, sWdata, wrLow};
    wire [47:0] popData;
    wire popValid;
    wire popReady = !arrayHold;
    wire [7:0] popAddr = popData[47:40];
    wire [3:0] popEn = popData[39:36];
    wire [35:0] popWord = popData[35:0];

    // loop and impedance counters
    reg [4:0] gapCount;
    reg [13:0] lockCount;
    reg [10:0] zqCount;
    // loop variable for lane writes
    integer lane;

    // two flop synchroniser and strobe edge flops
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            // idle pattern: no select looks active, no false strobe rise after reset
            syncA <= `DPS_SYNC_IDLE;
            syncB <= `DPS_SYNC_IDLE;
            posLast <= 1'b1;
            negLast <= 1'b1;
        end
        else
        begin
            syncA <= pinBus;
            syncB <= syncA;
            posLast <= sPos;
            negLast <= sNeg;
        end
    end

    // echo strobes follow the sampled input strobes
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            echoStrobePos <= 1'b0;
            echoStrobeNeg <= 1'b0;
        end
        else
        begin
            echoStrobePos <= sPos;
            echoStrobeNeg <= sNeg;
        end
    end

    // read pipeline and data output registers
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            // both ports idle, read outputs floating
            rdV0 <= 1'b0;
            rdV1 <= 1'b0;
            rdA0 <= 8'h0;
            rdA1 <= 8'h0;
            readData <= 18'h0;
            readDataOe <= 1'b0;
            beatHigh <= 18'h0;
            beatHighDue <= 1'b0;
        end
        else if (posRise)
        begin
            // select sampled only here; address into the read address stage
            rdV0 <= !sRpsN;
            rdA0 <= sAddr;
            rdV1 <= rdV0;
            rdA1 <= rdA0;
            // lookup at delivery sees every write already drained
            if (deliverV)
            begin
                // low beat on the positive edge
                readData <= deliverWord[17:0];
                beatHigh <= deliverWord[35:18];
                beatHighDue <= 1'b1;
                readDataOe <= 1'b1;
            end
            else
            begin
                // nothing pending: float after this edge
                beatHighDue <= 1'b0;
                readDataOe <= 1'b0;
            end
        end
        else if (negRise && beatHighDue)
        begin
            // high beat on the following negative edge
            readData <= beatHigh;
            beatHighDue <= 1'b0;
        end
    end

    // valid flag raised on the negative edge before the data
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            readValidFlag <= 1'b0;
        end
        else if (negRise)
        begin
            readValidFlag <= deliverV;
        end
    end

    // write capture on both strobes
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            wrPend <= 1'b0;
            wrLow <= 18'h0;
            wrLowEn <= 2'h0;
            writeDropped <= 1'b0;
        end
        else
        begin
            writeDropped <= pushValid && !writeReady;
            if (posRise)
            begin
                // deselected port takes no new burst
                wrPend <= !sWpsN;
                wrLow <= sWdata;
                wrLowEn <= ~sBwsN;
            end
            else if (negRise)
            begin
                // pending burst is finished by this edge
                wrPend <= 1'b0;
            end
        end
    end

    // write queue between the strobe side and the array
    dps_write_fifo #(
        .WIDTH(`DPS_FIFO_W),
        .DEPTH(`DPS_FIFO_DEPTH),
        .AW(`DPS_FIFO_AW)
    ) writeQueue (
        .clk(core_clk),
        .rstB(rst_b),
        .inData(pushData),
        .inValid(pushValid),
        .inReady(writeReady),
        .outData(popData),
        .outValid(popValid),
        .outReady(popReady)
    );

    // array update from the queue, lane by lane
    always @(posedge core_clk)
    begin
        if (popValid && popReady)
        begin
            for (lane = 0; lane < 4; lane = lane + 1)
            begin
                // disabled lane keeps its stored byte
                if (popEn[lane])
                begin
                    mem[popAddr][lane*`DPS_LANE_W +: `DPS_LANE_W] <=
                        popWord[lane*`DPS_LANE_W +: `DPS_LANE_W];
                end
            end
        end
    end

    // loop lock: count stable strobe cycles, restart on a stopped clock
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            gapCount <= 5'h0;
            lockCount <= 14'h0;
            dllLocked <= 1'b0;
        end
        else
        begin
            if (posRise || negRise)
            begin
                gapCount <= 5'h0;
            end
            else if (gapCount != 5'h1F)
            begin
                gapCount <= gapCount + 5'h1;
            end
            if (!sDllOn || gapCount > GAP_LIMIT)
            begin
                // loop off or clock stopped long enough
                lockCount <= 14'h0;
                dllLocked <= 1'b0;
            end
            else if (posRise && lockCount != LOCK_CYCLES)
            begin
                lockCount <= lockCount + 14'h1;
            end
            else if (lockCount == LOCK_CYCLES)
            begin
                dllLocked <= 1'b1;
            end
        end
    end

    // periodic impedance update from the reference pin
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            zqCount <= 11'h0;
            driveStrength <= 4'h0;
            impedanceUpdate <= 1'b0;
        end
        else
        begin
            impedanceUpdate <= 1'b0;
            if (posRise)
            begin
                if (zqCount == `DPS_ZQ_CYCLES - 11'h001)
                begin
                    zqCount <= 11'h0;
                    driveStrength <= sZq;
                    impedanceUpdate <= 1'b1;
                end
                else
                begin
                    zqCount <= zqCount + 11'h1;
                end
            end
        end
    end
endmodule // dps_sram_port
`default_nettype wire
